// ---- src/ldpi_consts.vh ----
// Constants for the laser driver pixel input port: offsets, fields, reset values, sizes.
// Assumes inclusion by bare name from the design files under src/.
// What this block does
// RULE1 - Capture and channel enables work only while the chip-enable pin is high.
// RULE2 - Power-saving request held high forces low-power mode until released.
// RULE3 - Pixel word bus is 15 lines carrying RGB amplitude data to channels.
// RULE4 - A new word is captured on every rising and every falling pixel clock edge.
// RULE5 - Three selectable formats using 15-bit or 10-bit pixel words.
// RULE6 - Lines 2, 4, 6 and 10 change role per control register 0x08 bits 2-0.
// RULE7 - Line 10 acts as frame sync only in format 2, ignored otherwise.
// RULE8 - Format 3 only: lines 2, 4, 6 gate channels 3, 2, 1.
// RULE9 - Input logic level chosen by bits 7-6 of 0x08, default 1.8V.
// RULE10 - Each channel's amplitude is latched from the bus on both clock edges.
// RULE11 - Outside format 3 shared lines are data; channels follow register enables only.
`ifndef LDPI_CONSTS_VH
`define LDPI_CONSTS_VH

`define LDPI_REG_CTRL 8'h08
`define LDPI_REG_STAT 8'h0C
`define LDPI_CTRL_RESET 8'h01
`define LDPI_FMT_MSB 2
`define LDPI_FMT_LSB 0
`define LDPI_EN_MSB 5
`define LDPI_EN_LSB 3
`define LDPI_LVL_MSB 7
`define LDPI_LVL_LSB 6
`define LDPI_LVL_1V8 2'h0
`define LDPI_FMT_WIDE 3'h1
`define LDPI_FMT_SYNC 3'h2
`define LDPI_FMT_GATE 3'h3
`define LDPI_BUS_W 15
`define LDPI_CH_W 10
`define LDPI_PIX_W 30
`define LDPI_FIFO_DEPTH 16
`define LDPI_FIFO_AW 4
`define LDPI_SYNC_LINE 10
`define LDPI_GATE1_LINE 6
`define LDPI_GATE2_LINE 4
`define LDPI_GATE3_LINE 2
`define LDPI_STAT_OVF 0
`define LDPI_STAT_POWER_SAVING_REQUEST 1
`define LDPI_STAT_ACT 2
`define LDPI_STAT_SYNC 3

`endif

// ---- src/ldpi_sync2.v ----
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the sampled inputs come from pins outside the CLK domain.
`timescale 1ns/1ps
module ldpi_sync2 #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rst_b,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] meta;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= {WIDTH{1'b0}};
         dout <= {WIDTH{1'b0}};
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

// ---- src/ldpi_fifo.v ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous-released active-low reset.
`timescale 1ns/1ps
module ldpi_fifo #(
   parameter WIDTH = 30,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire rst_b,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output reg [AW:0] count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   wire push;
   wire pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ---- src/ldpi_port.v ----
// Pixel input port of a three-channel laser driver: pin sampling, DDR word capture,
// format decoding, channel gating and the control/status registers.
// Assumes the pixel clock is far slower than CLK (at least three CLK cycles per half period)
// and that data lines are stable around each pixel clock edge.
`timescale 1ns/1ps
`include "ldpi_consts.vh"
module ldpi_port (
   input wire CLK,
   input wire RST_B,
   input wire CHIP_ENABLE,
   input wire POWER_SAVING_REQUEST,
   input wire PIXEL_CLOCK,
   input wire [`LDPI_BUS_W-1:0] PIXEL_WORD_LINES,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR_STB,
   input wire RD_STB,
   output reg [7:0] RDATA,
   output wire PIX_VALID,
   input wire PIX_READY,
   output wire [`LDPI_PIX_W-1:0] PIX_DATA,
   output reg [2:0] CHANNEL_ENABLE,
   output reg LOW_POWER,
   output reg [1:0] IO_LEVEL_SEL
);
   reg rst_q1;
   reg rst_q2;
   wire rst_b;

   wire [`LDPI_BUS_W+2:0] pins_s;
   wire ce_s;
   wire power_saving_request_s;
   wire pclk_s;
   wire [`LDPI_BUS_W-1:0] word_s;
   reg pclk_q;
   wire pclk_edge;

   reg [7:0] pixel_bus_control;
   reg overflow;
   reg sync_seen;
   wire [2:0] fmt;
   wire [2:0] reg_en;
   wire active;
   wire ctrl_wr;
   wire stat_wr;
   wire drop;
   wire [7:0] status_word;
   wire [2:0] line_gate;

   reg [1:0] phase;
   reg half;
   reg [`LDPI_CH_W-1:0] ch1;
   reg [`LDPI_CH_W-1:0] ch2;
   reg [`LDPI_BUS_W-1:0] low_word;
   reg [2:0] gate;
   reg pix_push;
   reg [`LDPI_PIX_W-1:0] pix_word;
   wire fifo_in_ready;
   wire [`LDPI_FIFO_AW:0] fifo_count;

   reg [`LDPI_CH_W-1:0] narrow;
   reg next_push;
   reg [`LDPI_PIX_W-1:0] next_pix;
   reg [1:0] next_phase;
   reg next_half;
   reg [`LDPI_CH_W-1:0] next_ch1;
   reg [`LDPI_CH_W-1:0] next_ch2;
   reg [`LDPI_BUS_W-1:0] next_low;
   reg [2:0] next_gate;
   reg next_sync_seen;

   // Channel slot that the next 10-bit word fills in formats 2 and 3
   localparam PH_CH1 = 2'h0;
   localparam PH_CH2 = 2'h1;
   localparam PH_CH3 = 2'h2;

   // Reset released through two flops so every register leaves reset on the same edge
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end
   assign rst_b = rst_q2;

   // Pins share one synchroniser so data and pixel clock keep the same latency
   ldpi_sync2 #(
      .WIDTH(`LDPI_BUS_W + 3)
   ) u_sync (
      .clk(CLK),
      .rst_b(rst_b),
      .din({CHIP_ENABLE, POWER_SAVING_REQUEST, PIXEL_CLOCK, PIXEL_WORD_LINES}),
      .dout(pins_s)
   );
   assign ce_s = pins_s[`LDPI_BUS_W+2];
   assign power_saving_request_s = pins_s[`LDPI_BUS_W+1];
   assign pclk_s = pins_s[`LDPI_BUS_W];
   assign word_s = pins_s[`LDPI_BUS_W-1:0];
   assign line_gate = {word_s[`LDPI_GATE3_LINE], word_s[`LDPI_GATE2_LINE],
                       word_s[`LDPI_GATE1_LINE]};

   // Edge detector starts at the idle low level of the pixel clock: no false edge after reset
   always @(posedge CLK or negedge rst_b) begin
      if (!rst_b) begin
         pclk_q <= 1'b0;
      end else begin
         pclk_q <= pclk_s;
      end
   end
   assign pclk_edge = pclk_s ^ pclk_q; // RULE4

   assign fmt = pixel_bus_control[`LDPI_FMT_MSB:`LDPI_FMT_LSB]; // RULE6
   assign reg_en = pixel_bus_control[`LDPI_EN_MSB:`LDPI_EN_LSB];
   assign active = ce_s && !power_saving_request_s; // RULE1 RULE2

   // In format 3 lines 6, 4 and 2 are gates, so the channel word skips them, line 10 and line 0
   always @* begin
      if (fmt == `LDPI_FMT_GATE) begin
         narrow = {word_s[14:11], word_s[9:7], word_s[5], word_s[3], word_s[1]};
      end else begin
         narrow = word_s[`LDPI_CH_W-1:0];
      end
   end

   // Capture path; the link cannot be stalled, so a full FIFO drops the pixel
   // and records it in the sticky overflow flag
   always @* begin
      next_push = 1'b0;
      next_pix = pix_word;
      next_phase = phase;
      next_half = half;
      next_ch1 = ch1;
      next_ch2 = ch2;
      next_low = low_word;
      next_gate = gate;
      next_sync_seen = 1'b0;
      if (!active) begin
         next_phase = PH_CH1;
         next_half = 1'b0;
      end else if (pclk_edge) begin // RULE10
         case (fmt)
            `LDPI_FMT_WIDE: begin // RULE5
               if (pclk_s) begin
                  next_low = word_s; // RULE3
                  next_half = 1'b1;
               end else if (half) begin
                  next_pix = {word_s, low_word};
                  next_push = 1'b1;
                  next_half = 1'b0;
               end
            end
            `LDPI_FMT_SYNC, `LDPI_FMT_GATE: begin // RULE5
               // In format 2 a word with the sync line high always opens a new pixel as channel 1
               if (fmt == `LDPI_FMT_SYNC && word_s[`LDPI_SYNC_LINE]) begin // RULE7
                  next_sync_seen = 1'b1;
                  next_ch1 = narrow;
                  next_phase = PH_CH2;
               end else begin
                  case (phase)
                     PH_CH1: begin
                        next_ch1 = narrow;
                        next_phase = PH_CH2;
                     end
                     PH_CH2: begin
                        next_ch2 = narrow;
                        next_phase = PH_CH3;
                     end
                     default: begin
                        next_pix = {narrow, ch2, ch1};
                        next_push = 1'b1;
                        next_phase = PH_CH1;
                     end
                  endcase
               end
               if (fmt == `LDPI_FMT_GATE) begin // RULE8
                  next_gate = line_gate;
               end
            end
            default: begin
               next_phase = PH_CH1;
               next_half = 1'b0;
            end
         endcase
      end
   end

   always @(posedge CLK or negedge rst_b) begin
      if (!rst_b) begin
         phase <= PH_CH1;
         half <= 1'b0;
         ch1 <= {`LDPI_CH_W{1'b0}};
         ch2 <= {`LDPI_CH_W{1'b0}};
         low_word <= {`LDPI_BUS_W{1'b0}};
         gate <= 3'h0;
         pix_push <= 1'b0;
         pix_word <= {`LDPI_PIX_W{1'b0}};
      end else begin
         phase <= next_phase;
         half <= next_half;
         ch1 <= next_ch1;
         ch2 <= next_ch2;
         low_word <= next_low;
         gate <= next_gate;
         pix_push <= next_push;
         pix_word <= next_pix;
      end
   end

   // Sixteen words absorb sink stalls, since the link itself cannot be held off
   ldpi_fifo #(
      .WIDTH(`LDPI_PIX_W),
      .DEPTH(`LDPI_FIFO_DEPTH),
      .AW(`LDPI_FIFO_AW)
   ) u_fifo (
      .clk(CLK),
      .rst_b(rst_b),
      .in_valid(pix_push),
      .in_ready(fifo_in_ready),
      .in_data(pix_word),
      .out_valid(PIX_VALID),
      .out_ready(PIX_READY),
      .out_data(PIX_DATA),
      .count(fifo_count)
   );

   // Channel gating and power outputs
   always @(posedge CLK or negedge rst_b) begin
      if (!rst_b) begin
         CHANNEL_ENABLE <= 3'h0;
         LOW_POWER <= 1'b0;
         IO_LEVEL_SEL <= `LDPI_LVL_1V8;
      end else begin
         LOW_POWER <= power_saving_request_s; // RULE2
         IO_LEVEL_SEL <= pixel_bus_control[`LDPI_LVL_MSB:`LDPI_LVL_LSB]; // RULE9
         if (!active) begin
            CHANNEL_ENABLE <= 3'h0; // RULE1
         end else if (fmt == `LDPI_FMT_GATE) begin
            CHANNEL_ENABLE <= reg_en & gate; // RULE8
         end else begin
            CHANNEL_ENABLE <= reg_en; // RULE11
         end
      end
   end

   assign ctrl_wr = WR_STB && (ADDR == `LDPI_REG_CTRL);
   assign stat_wr = WR_STB && (ADDR == `LDPI_REG_STAT);
   assign drop = pix_push && !fifo_in_ready;
   // Only four count bits fit the status word, so a full FIFO reads as zero there
   assign status_word = {fifo_count[`LDPI_FIFO_AW-1:0], sync_seen, active, power_saving_request_s, overflow};

   always @(posedge CLK or negedge rst_b) begin
      if (!rst_b) begin
         pixel_bus_control <= `LDPI_CTRL_RESET; // RULE9
      end else if (ctrl_wr) begin
         pixel_bus_control <= WDATA; // RULE6
      end
   end

   // Sticky status bits clear by writing 1; an event in the same cycle wins over the clear
   always @(posedge CLK or negedge rst_b) begin
      if (!rst_b) begin
         overflow <= 1'b0;
         sync_seen <= 1'b0;
      end else begin
         if (drop) begin
            overflow <= 1'b1;
         end else if (stat_wr && WDATA[`LDPI_STAT_OVF]) begin
            overflow <= 1'b0;
         end
         if (next_sync_seen) begin
            sync_seen <= 1'b1;
         end else if (stat_wr && WDATA[`LDPI_STAT_SYNC]) begin
            sync_seen <= 1'b0;
         end
      end
   end

   // Read data stand for one cycle only and read zero otherwise
   always @(posedge CLK or negedge rst_b) begin
      if (!rst_b) begin
         RDATA <= 8'h00;
      end else if (RD_STB) begin
         case (ADDR)
            `LDPI_REG_CTRL: begin
               RDATA <= pixel_bus_control;
            end
            `LDPI_REG_STAT: begin
               RDATA <= status_word;
            end
            default: begin
               RDATA <= 8'h00;
            end
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end
endmodule

// ---- verification/ldpi_props.sv ----
// Checker for the pixel input port: register bus, power pins, gating and FIFO hold.
// Assumes it is bound to ldpi_port and sees only its ports.
`timescale 1ns/1ps
module ldpi_props (
   input wire CLK,
   input wire RST_B,
   input wire CHIP_ENABLE,
   input wire POWER_SAVING_REQUEST,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR_STB,
   input wire RD_STB,
   input wire [7:0] RDATA,
   input wire PIX_VALID,
   input wire PIX_READY,
   input wire [29:0] PIX_DATA,
   input wire [2:0] CHANNEL_ENABLE,
   input wire LOW_POWER,
   input wire [1:0] IO_LEVEL_SEL
);
   reg [7:0] ctrl;
   wire ctl_wr = WR_STB && ADDR == 8'h08;
   wire [1:0] lvl = WDATA[7:6];
   // Mirror of the control register, so gating can be judged from the ports
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B)
         ctrl <= 8'h01;
      else if (ctl_wr)
         ctrl <= WDATA;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence ctl_write_read;
      ctl_wr ##1 (RD_STB && ADDR == 8'h08);
   endsequence
   sequence lone_write;
      ctl_wr ##1 !ctl_wr;
   endsequence
   readback_a: assert property (ctl_write_read |=> RDATA == $past(WDATA, 2))
      else $error("control readback differs from write");
   read_idle_a: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
      else $error("read data outside answer cycle");
   level_sel_a: assert property (lone_write |=> IO_LEVEL_SEL == $past(lvl, 2))
      else $error("level select does not follow write");
   ce_off_a: assert property (!CHIP_ENABLE [*5] |-> CHANNEL_ENABLE == 3'h0)
      else $error("channel on while chip disabled");
   power_saving_request_on_a: assert property (POWER_SAVING_REQUEST [*5] |-> LOW_POWER && CHANNEL_ENABLE == 3'h0)
      else $error("low power not entered");
   power_saving_request_off_a: assert property (!POWER_SAVING_REQUEST [*5] |-> !LOW_POWER)
      else $error("low power not left");
   en_subset_a: assert property ((!ctl_wr) [*3] |-> (CHANNEL_ENABLE & ~ctrl[5:3]) == 3'h0)
      else $error("channel on without register enable");
   plain_en_a: assert property ((CHIP_ENABLE && !POWER_SAVING_REQUEST && ctrl[2:0] != 3'h3
      && !ctl_wr) [*5] |-> CHANNEL_ENABLE == ctrl[5:3])
      else $error("enables differ from register outside gate format");
   pix_hold_a: assert property (PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_DATA))
      else $error("pixel lost while stalled");
endmodule
bind ldpi_port ldpi_props u_props (.CLK, .RST_B, .CHIP_ENABLE, .POWER_SAVING_REQUEST, .ADDR,
   .WDATA, .WR_STB, .RD_STB, .RDATA, .PIX_VALID, .PIX_READY, .PIX_DATA, .CHANNEL_ENABLE,
   .LOW_POWER, .IO_LEVEL_SEL);

// ---- verification/ldpi_video_src.sv ----
// Model of the external video controller driving the pixel clock and word lines.
// Assumes one call of send_word per pixel clock half period of 100 ns.
`timescale 1ns/1ps
module ldpi_video_src (
   output logic pix_clk,
   output logic [14:0] lines
);
   initial begin
      pix_clk = 1'b0;
      lines = 15'h0000;
   end
   // Clock stands still between calls; data set 50 ns before its edge, held 40 ns after
   task automatic send_word(input logic [14:0] w);
      lines = w;
      #50;
      pix_clk = ~pix_clk;
      #40;
      lines = ~w; // Past hold time the bus shows no stale word
      #10;
   endtask
endmodule

// ---- verification/ldpi_port_test.sv ----
// Testbench for the pixel input port: registers, pins, three formats and the FIFO.
// Assumes ldpi_port, its checker and the video source model are compiled first.
`timescale 1ns/1ps
`define LDPI_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module ldpi_port_test;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic CHIP_ENABLE = 1'b0;
   logic POWER_SAVING_REQUEST = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic WR_STB = 1'b0;
   logic RD_STB = 1'b0;
   logic PIX_READY = 1'b0;
   logic [7:0] RDATA;
   logic PIX_VALID;
   logic LOW_POWER;
   logic [29:0] PIX_DATA;
   logic [2:0] CHANNEL_ENABLE;
   logic [1:0] IO_LEVEL_SEL;
   wire pclk;
   wire [14:0] lines;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 12352;
   logic [29:0] expq[$];
   logic [14:0] ws[7];
   logic [7:0] lv;
   always #12.5 CLK = ~CLK;
   ldpi_video_src u_src (.pix_clk(pclk), .lines(lines));
   ldpi_port u_dut (.CLK, .RST_B, .CHIP_ENABLE, .POWER_SAVING_REQUEST, .PIXEL_CLOCK(pclk),
      .PIXEL_WORD_LINES(lines), .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA, .PIX_VALID,
      .PIX_READY, .PIX_DATA, .CHANNEL_ENABLE, .LOW_POWER, .IO_LEVEL_SEL);
   function automatic logic [9:0] f3(input logic [14:0] w);
      return {w[14:11], w[9:7], w[5], w[3], w[1]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR_STB <= 1'b1;
      @(posedge CLK);
      WR_STB <= 1'b0;
   endtask
   // Write then read the same register with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR_STB <= 1'b1;
      @(posedge CLK);
      WR_STB <= 1'b0;
      RD_STB <= 1'b1;
      @(posedge CLK);
      RD_STB <= 1'b0;
      #1;
      `LDPI_CHK(RDATA, d)
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge CLK);
      RD_STB <= 1'b0;
      #1;
      `LDPI_CHK(RDATA, e)
   endtask
   task automatic pop(input logic [29:0] e);
      int n;
      n = 0;
      while (PIX_VALID !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      `LDPI_CHK(PIX_DATA, e)
      @(posedge CLK);
      PIX_READY <= 1'b1;
      @(posedge CLK);
      PIX_READY <= 1'b0;
      #1;
   endtask
   task close_out;
      $display("errors %0d, comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out;
      end
   end
   initial begin
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLK);
      rd(8'h08, 8'h01);
      `LDPI_CHK(IO_LEVEL_SEL, 2'h0)
      rd(8'h33, 8'h00);
      lv = $random(seed);
      wr(8'h08, {lv[7:6], 6'h39});
      rd(8'h08, {lv[7:6], 6'h39});
      `LDPI_CHK(IO_LEVEL_SEL, lv[7:6])
      step(6);
      `LDPI_CHK(CHANNEL_ENABLE, 3'h0)
      @(posedge CLK) CHIP_ENABLE <= 1'b1;
      step(6);
      `LDPI_CHK(CHANNEL_ENABLE, 3'h7)
      @(posedge CLK) POWER_SAVING_REQUEST <= 1'b1;
      step(6);
      `LDPI_CHK({LOW_POWER, CHANNEL_ENABLE}, 4'h8)
      @(posedge CLK) POWER_SAVING_REQUEST <= 1'b0;
      step(6);
      `LDPI_CHK({LOW_POWER, CHANNEL_ENABLE}, 4'h7)
      // Wide format with the sink stalled: seventeenth pixel overflows
      repeat (17) begin
         ws[0] = $random(seed);
         ws[1] = $random(seed);
         expq.push_back({ws[1], ws[0]});
         u_src.send_word(ws[0]);
         u_src.send_word(ws[1]);
      end
      step(10);
      rd(8'h0C, 8'h05);
      repeat (16) pop(expq.pop_front());
      wr_rd(8'h08, {lv[7:6], 6'h3A});
      for (int i = 0; i < 7; i++) begin
         ws[i] = $random(seed);
         ws[i][10] = (i == 0 || i == 4);
         u_src.send_word(ws[i]);
      end
      step(10);
      pop({ws[2][9:0], ws[1][9:0], ws[0][9:0]});
      pop({ws[6][9:0], ws[5][9:0], ws[4][9:0]});
      rd(8'h0C, 8'h0D);
      wr(8'h0C, 8'h09);
      rd(8'h0C, 8'h04);
      wr(8'h08, {lv[7:6], 6'h3B});
      // A sync mark in format 3 must not restart the pixel
      for (int i = 0; i < 3; i++) begin
         ws[i] = $random(seed);
         ws[i][10] = (i == 1);
         u_src.send_word(ws[i]);
      end
      step(10);
      `LDPI_CHK(CHANNEL_ENABLE, {ws[2][2], ws[2][4], ws[2][6]})
      pop({f3(ws[2]), f3(ws[1]), f3(ws[0])});
      // Format 0 captures nothing and leaves the enables to the register
      wr(8'h08, {lv[7:6], 6'h38});
      ws[0] = $random(seed);
      ws[1] = $random(seed);
      u_src.send_word(ws[0]);
      u_src.send_word(ws[1]);
      step(10);
      `LDPI_CHK(PIX_VALID, 1'b0)
      `LDPI_CHK(CHANNEL_ENABLE, 3'h7)
      close_out;
   end
endmodule
